// ---- verilog/rtoa_top.sv ----
// remote temperature offset stage with serial bus target and alarms
// What this block does, and what its host should do (R10)
// R1: add programmable signed two's-complement offset to converted temperature.
// R2: one offset value shared by every selected remote channel.
// R3: offset bit 7 is sign, bits 6..0 weigh 16 down to 0.25 degrees.
// R4: offset register at 4Dh, resets to zero.
// R5: enable register at 4Eh, bit n-1 enables remote n, bit 7 unused.
// R6: with extended range off, result never below 00h.
// R7: with extended range on, result never above FFh.
// R8: open or shorted remote diode is flagged as fault in status.
// R9: faulted remote channel is skipped in the measurement sequence.
// R10: host should mask unused channels in both alarm masks at power-up.
// R11: masked channel never asserts warning or shutdown alarm output.
// R12: answer only target address 1001101, bit A0 is read/write.
// R13: disabled remote channels and the local channel get no offset.
`timescale 1ns/100ps
module rtoa_top
   import rtoa_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // serial bus pins
   input wire logic sclIn,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOeN,
   // open-drain alarm pins
   output logic alertOut,
   output logic alertOeN,
   output logic shutdownAlarmOut,
   output logic shutdownAlarmOeN,
   // converter front end
   output logic convStart,
   output logic [2:0] convChan,
   input wire logic convDone,
   input wire logic [RAW_W-1:0] convRaw,
   input wire logic convFault
);
   ////////////////////////////////////////////////////////////////////
   // serial bus target
   rtoa_bus_state_t bus_q;
   logic sclPrev_q, sdaPrev_q;
   logic [7:0] shift_q, ptr_q;
   logic [3:0] bitCnt_q;
   logic rw_q, acked_q, sdaLow_q;
   logic wrEn_q;
   logic [7:0] wrData_q;
   logic startSeen, stopSeen, sclRise, sclFall, byteFull, addrHit;
   logic [7:0] readData;

   assign startSeen = sclIn && sclPrev_q && sdaPrev_q && !sdaIn;
   assign stopSeen = sclIn && sclPrev_q && !sdaPrev_q && sdaIn;
   assign sclRise = sclIn && !sclPrev_q;
   assign sclFall = !sclIn && sclPrev_q;
   assign byteFull = (bitCnt_q == BYTE_BITS);
   assign addrHit = (shift_q[7:1] == TARGET_ADDR); // [R12]

   // pin history for edge and start/stop detection
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         sclPrev_q <= 1'b1;
         sdaPrev_q <= 1'b1;
      end else begin
         sclPrev_q <= sclIn;
         sdaPrev_q <= sdaIn;
      end
   end

   // byte engine: sample on scl rise, change sda on scl fall
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         bus_q <= BUS_IDLE;
         shift_q <= REG_RESET;
         ptr_q <= REG_RESET;
         bitCnt_q <= 4'h0;
         rw_q <= 1'b0;
         acked_q <= 1'b0;
         sdaLow_q <= 1'b0;
         wrEn_q <= 1'b0;
         wrData_q <= REG_RESET;
      end else begin
         wrEn_q <= 1'b0;
         if (startSeen) begin
            bus_q <= BUS_ADDR;
            bitCnt_q <= 4'h0;
            sdaLow_q <= 1'b0;
         end else if (stopSeen) begin
            bus_q <= BUS_IDLE;
            sdaLow_q <= 1'b0;
         end else begin
            case (bus_q)
               BUS_ADDR, BUS_CMD, BUS_WR: begin
                  if (sclRise && !byteFull) begin
                     shift_q <= {shift_q[6:0], sdaIn};
                     bitCnt_q <= bitCnt_q + 4'h1;
                  end else if (sclFall && byteFull) begin
                     bitCnt_q <= 4'h0;
                     sdaLow_q <= 1'b1;
                     if (bus_q == BUS_ADDR) begin
                        // foreign address: stay silent until next start
                        bus_q <= addrHit ? BUS_ACK_ADDR : BUS_IDLE; // [R12]
                        sdaLow_q <= addrHit;
                        rw_q <= shift_q[0];
                     end else if (bus_q == BUS_CMD) begin
                        ptr_q <= shift_q;
                        bus_q <= BUS_ACK_CMD;
                     end else begin
                        wrEn_q <= 1'b1;
                        wrData_q <= shift_q;
                        bus_q <= BUS_ACK_WR;
                     end
                  end
               end
               BUS_ACK_ADDR: begin
                  if (sclFall) begin
                     if (rw_q) begin
                        shift_q <= readData;
                        sdaLow_q <= !readData[7];
                        bus_q <= BUS_RD;
                     end else begin
                        sdaLow_q <= 1'b0;
                        bus_q <= BUS_CMD;
                     end
                  end
               end
               BUS_ACK_CMD, BUS_ACK_WR: begin
                  if (sclFall) begin
                     sdaLow_q <= 1'b0;
                     bus_q <= BUS_WR;
                  end
               end
               BUS_RD: begin
                  if (sclRise) begin
                     bitCnt_q <= bitCnt_q + 4'h1;
                  end else if (sclFall && byteFull) begin
                     sdaLow_q <= 1'b0;
                     bitCnt_q <= 4'h0;
                     bus_q <= BUS_ACK_RD;
                  end else if (sclFall) begin
                     shift_q <= {shift_q[6:0], 1'b0};
                     sdaLow_q <= !shift_q[6];
                  end
               end
               BUS_ACK_RD: begin
                  if (sclRise) begin
                     acked_q <= !sdaIn;
                  end else if (sclFall) begin
                     // a nack ends the read; an ack repeats the register
                     bus_q <= acked_q ? BUS_RD : BUS_IDLE;
                     shift_q <= readData;
                     sdaLow_q <= acked_q && !readData[7];
                  end
               end
               default: begin
                  bus_q <= BUS_IDLE;
               end
            endcase
         end
      end
   end

   assign sdaOut = 1'b0;
   assign sdaOeN = !sdaLow_q;

   ////////////////////////////////////////////////////////////////////
   // register file
   logic [7:0] offset_q, offsetEn_q, config_q;
   logic [7:0] alertLimit_q, shdnLimit_q, alertMask_q, shdnMask_q;
   logic [7:0] alertStat_q, shdnStat_q;
   logic [6:0] fault_q;
   logic [7:0] temp_q [0:NUM_CHAN-1];
   logic wrOffset, wrEnable, wrConfig, wrFault;
   logic wrAlertLim, wrShdnLim, wrAlertMask, wrShdnMask;
   logic [6:0] faultSet, faultClr;

   assign wrOffset = wrEn_q && (ptr_q == REG_SHARED_OFFSET); // [R4]
   assign wrEnable = wrEn_q && (ptr_q == REG_OFFSET_ENABLE); // [R5]
   assign wrConfig = wrEn_q && (ptr_q == REG_CONFIG);
   assign wrFault = wrEn_q && (ptr_q == REG_DIODE_FAULT);
   assign wrAlertLim = wrEn_q && (ptr_q == REG_ALERT_LIMIT);
   assign wrShdnLim = wrEn_q && (ptr_q == REG_SHDN_LIMIT);
   assign wrAlertMask = wrEn_q && (ptr_q == REG_ALERT_MASK);
   assign wrShdnMask = wrEn_q && (ptr_q == REG_SHDN_MASK);
   assign faultClr = wrFault ? wrData_q[6:0] : 7'h00;

   // host-written settings, all zero at power-on
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         offset_q <= REG_RESET; // [R4]
         offsetEn_q <= REG_RESET; // [R5]
         config_q <= REG_RESET;
         alertLimit_q <= REG_RESET;
         shdnLimit_q <= REG_RESET;
         alertMask_q <= REG_RESET;
         shdnMask_q <= REG_RESET;
      end else begin
         if (wrOffset) offset_q <= wrData_q; // [R3] [R4]
         if (wrEnable) offsetEn_q <= wrData_q & OFFSET_ENABLE_BITS; // [R5]
         if (wrConfig) config_q <= wrData_q & CONFIG_BITS;
         if (wrAlertLim) alertLimit_q <= wrData_q;
         if (wrShdnLim) shdnLimit_q <= wrData_q;
         if (wrAlertMask) alertMask_q <= wrData_q; // [R11]
         if (wrShdnMask) shdnMask_q <= wrData_q; // [R11]
      end
   end

   // read selection; unmapped offsets read as zero
   assign readData =
      (ptr_q <= REG_TEMP_LAST) ? temp_q[ptr_q[2:0]] :
      (ptr_q == REG_CONFIG) ? config_q :
      (ptr_q == REG_ALERT_LIMIT) ? alertLimit_q :
      (ptr_q == REG_SHDN_LIMIT) ? shdnLimit_q :
      (ptr_q == REG_ALERT_MASK) ? alertMask_q :
      (ptr_q == REG_SHDN_MASK) ? shdnMask_q :
      (ptr_q == REG_DIODE_FAULT) ? {1'b0, fault_q} : // [R8]
      (ptr_q == REG_ALERT_STAT) ? alertStat_q :
      (ptr_q == REG_SHDN_STAT) ? shdnStat_q :
      (ptr_q == REG_SHARED_OFFSET) ? offset_q :
      (ptr_q == REG_OFFSET_ENABLE) ? offsetEn_q : READ_UNMAPPED;

   ////////////////////////////////////////////////////////////////////
   // measurement sequencer
   rtoa_seq_state_t seq_q;
   logic [2:0] chan_q;
   logic adjValid_q;
   logic [RAW_W-1:0] raw_q;
   logic isRemote, skipChan, remoteFault, storeResult;
   logic [2:0] faultIdx;
   logic [7:0] chanBit;
   rtoa_adj_if adjBus ();

   assign isRemote = (chan_q != LOCAL_CHAN);
   assign faultIdx = chan_q - 3'h1;
   assign chanBit = 8'h01 << chan_q;
   // faulted remotes are passed over without starting a conversion
   assign skipChan = isRemote && fault_q[faultIdx]; // [R9]
   assign remoteFault = (seq_q == SEQ_CONV) && convDone && convFault &&
      isRemote; // [R8]
   assign storeResult = (seq_q == SEQ_ADJ) && adjBus.resultValid;
   assign faultSet = remoteFault ? chanBit[7:1] : 7'h00; // [R8]
   assign convStart = (seq_q == SEQ_PICK) && !skipChan; // [R9]
   assign convChan = chan_q;

   // step through the channels, one conversion at a time
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         seq_q <= SEQ_PICK;
         chan_q <= LOCAL_CHAN;
         adjValid_q <= 1'b0;
         raw_q <= '0;
      end else begin
         adjValid_q <= 1'b0;
         case (seq_q)
            SEQ_PICK: begin
               if (skipChan) chan_q <= chan_q + 3'h1; // [R9]
               else seq_q <= SEQ_CONV;
            end
            SEQ_CONV: begin
               if (convDone && remoteFault) begin
                  chan_q <= chan_q + 3'h1;
                  seq_q <= SEQ_PICK;
               end else if (convDone) begin
                  raw_q <= convRaw;
                  adjValid_q <= 1'b1;
                  seq_q <= SEQ_ADJ;
               end
            end
            SEQ_ADJ: begin
               if (adjBus.resultValid) begin
                  chan_q <= chan_q + 3'h1;
                  seq_q <= SEQ_PICK;
               end
            end
            default: begin
               seq_q <= SEQ_PICK;
            end
         endcase
      end
   end

   assign adjBus.valid = adjValid_q;
   assign adjBus.chan = chan_q;
   assign adjBus.raw = raw_q;
   assign adjBus.offset = offset_q; // [R2]
   assign adjBus.enableMask = offsetEn_q[6:0];
   assign adjBus.extended_range_select = config_q[CFG_EXT_RANGE_BIT];

   rtoa_offset_clamp adjust (
      .clk (clk),
      .reset (reset),
      .adj (adjBus.adjuster)
   );

   ////////////////////////////////////////////////////////////////////
   // results, diode faults and alarm status
   genvar ch;
   generate
      for (ch = 0; ch < NUM_CHAN; ch = ch + 1) begin : g_chan
         logic hit;
         assign hit = storeResult && (chan_q == ch);
         always_ff @(posedge clk or posedge reset) begin
            if (reset) begin
               temp_q[ch] <= REG_RESET;
               alertStat_q[ch] <= 1'b0;
               shdnStat_q[ch] <= 1'b0;
            end else if (hit) begin
               temp_q[ch] <= adjBus.result;
               alertStat_q[ch] <= adjBus.result > alertLimit_q;
               shdnStat_q[ch] <= adjBus.result > shdnLimit_q;
            end else if (remoteFault && (chan_q == ch)) begin
               // a dead diode must not hold a stale alarm
               alertStat_q[ch] <= 1'b0;
               shdnStat_q[ch] <= 1'b0;
            end
         end
      end
   endgenerate

   // write one to clear; a fault found in the same cycle still sticks
   always_ff @(posedge clk or posedge reset) begin
      if (reset) fault_q <= 7'h00;
      else fault_q <= (fault_q & ~faultClr) | faultSet; // [R8]
   end

   // alarm pins: masked channels cannot pull them low
   logic alertAct_q, shdnAct_q;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         alertAct_q <= 1'b0;
         shdnAct_q <= 1'b0;
      end else begin
         alertAct_q <= |(alertStat_q & ~alertMask_q); // [R11]
         shdnAct_q <= |(shdnStat_q & ~shdnMask_q); // [R11]
      end
   end

   assign alertOut = 1'b0;
   assign alertOeN = !alertAct_q;
   assign shutdownAlarmOut = 1'b0;
   assign shutdownAlarmOeN = !shdnAct_q;
endmodule

// ---- verilog/rtoa_pkg.sv ----
// constants and types shared by the remote temperature offset stage
package rtoa_pkg;
   // serial bus target address, bits A7..A1
   localparam logic [6:0] TARGET_ADDR = 7'h4d;
   // register map
   localparam logic [7:0] REG_TEMP_BASE = 8'h00;
   localparam logic [7:0] REG_TEMP_LAST = 8'h07;
   localparam logic [7:0] REG_CONFIG = 8'h08;
   localparam logic [7:0] REG_ALERT_LIMIT = 8'h09;
   localparam logic [7:0] REG_SHDN_LIMIT = 8'h0a;
   localparam logic [7:0] REG_ALERT_MASK = 8'h0b;
   localparam logic [7:0] REG_SHDN_MASK = 8'h0c;
   localparam logic [7:0] REG_DIODE_FAULT = 8'h0d;
   localparam logic [7:0] REG_ALERT_STAT = 8'h0e;
   localparam logic [7:0] REG_SHDN_STAT = 8'h0f;
   localparam logic [7:0] REG_SHARED_OFFSET = 8'h4d;
   localparam logic [7:0] REG_OFFSET_ENABLE = 8'h4e;
   // field layout and reset values
   localparam int CFG_EXT_RANGE_BIT = 0;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [7:0] OFFSET_ENABLE_BITS = 8'h7f;
   localparam logic [7:0] CONFIG_BITS = 8'h01;
   localparam logic [7:0] READ_UNMAPPED = 8'h00;
   // data path
   localparam int NUM_CHAN = 8;
   localparam int RAW_W = 12;
   localparam logic [10:0] EXT_RANGE_SHIFT = 11'h040;
   localparam logic [7:0] CLAMP_LOW = 8'h00;
   localparam logic [7:0] CLAMP_HIGH = 8'hff;
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam logic [2:0] LOCAL_CHAN = 3'h0;

   typedef enum logic [3:0] {
      BUS_IDLE, BUS_ADDR, BUS_ACK_ADDR, BUS_CMD, BUS_ACK_CMD,
      BUS_WR, BUS_ACK_WR, BUS_RD, BUS_ACK_RD
   } rtoa_bus_state_t;

   typedef enum logic [1:0] {
      SEQ_PICK, SEQ_CONV, SEQ_ADJ
   } rtoa_seq_state_t;
endpackage

// ---- verilog/rtoa_adj_if.sv ----
// carrier between the sequencer and the offset/clamp stage
`timescale 1ns/100ps
interface rtoa_adj_if;
   import rtoa_pkg::*;
   logic valid;
   logic [2:0] chan;
   logic [RAW_W-1:0] raw;
   logic [7:0] offset;
   logic [6:0] enableMask;
   logic extended_range_select;
   logic resultValid;
   logic [7:0] result;

   modport requester (output valid, chan, raw, offset, enableMask,
      extended_range_select, input resultValid, result);
   modport adjuster (input valid, chan, raw, offset, enableMask,
      extended_range_select, output resultValid, result);
endinterface

// ---- verilog/rtoa_offset_clamp.sv ----
// shared offset addition and range clamp for one conversion result
`timescale 1ns/100ps
module rtoa_offset_clamp
   import rtoa_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // conversion result in, adjusted byte out
   rtoa_adj_if.adjuster adj
);
   logic applyOffset;
   logic [2:0] enIdx;
   logic signed [12:0] addend;
   logic signed [12:0] sumQ4;
   logic signed [10:0] degrees;
   logic signed [10:0] shifted;
   logic underflow;
   logic overflow;
   logic [7:0] clamped;
   logic resultValid_q;
   logic [7:0] result_q;

   // local channel never gets the offset; remote n uses enable bit n-1
   assign enIdx = adj.chan - 3'h1;
   assign applyOffset = (adj.chan != LOCAL_CHAN) &&
      adj.enableMask[enIdx]; // [R2] [R13]
   assign addend = applyOffset ? {{5{adj.offset[7]}}, adj.offset}
      : 13'sh0000; // [R1] [R3]
   // raw and offset are both in quarter degrees, so no scaling first
   assign sumQ4 = $signed({adj.raw[RAW_W-1], adj.raw}) + addend; // [R1]
   // drop the two fraction bits; floor keeps negatives monotonic
   assign degrees = sumQ4[12:2];
   assign shifted = adj.extended_range_select ? degrees + $signed(EXT_RANGE_SHIFT)
      : degrees;
   assign underflow = shifted[10];
   assign overflow = !shifted[10] && (shifted[9:8] != 2'b00);
   // saturate both ends so a large offset can never wrap the byte
   assign clamped = underflow ? CLAMP_LOW : // [R6]
      overflow ? CLAMP_HIGH : shifted[7:0]; // [R7]

   // result registered one cycle after the request
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         resultValid_q <= 1'b0;
         result_q <= REG_RESET;
      end else begin
         resultValid_q <= adj.valid;
         if (adj.valid) begin
            result_q <= clamped;
         end
      end
   end

   assign adj.resultValid = resultValid_q;
   assign adj.result = result_q;
endmodule

// ---- tb/rtoa_checker.sv ----
// pin-level checks on the offset stage top module
`timescale 1ns/100ps
module rtoa_checker
   import rtoa_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // serial bus pins
   input wire logic sclIn,
   input wire logic sdaIn,
   input wire logic sdaOut,
   input wire logic sdaOeN,
   // alarm pins
   input wire logic alertOut,
   input wire logic alertOeN,
   input wire logic shutdownAlarmOut,
   input wire logic shutdownAlarmOeN,
   // converter front end
   input wire logic convStart,
   input wire logic [2:0] convChan,
   input wire logic convDone,
   input wire logic [RAW_W-1:0] convRaw,
   input wire logic convFault
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   // three idle cycles, from the good result on, while the adjust stage works
   sequence s_quiet;
      !convStart ##1 !convStart ##1 !convStart;
   endsequence
   // open-drain pins only pull low, and all start released after reset
   property p_od_low;
      (!sdaOut && !alertOut && !shutdownAlarmOut) and
         ($fell(reset) |-> sdaOeN && alertOeN && shutdownAlarmOeN);
   endproperty
   a_od_low: assert property (p_od_low)
      else $error("open-drain pin driven high");
   // data line moves only while the bus clock is low
   property p_sda_change;
      $changed(sdaOeN) |-> !sclIn && !$past(sclIn);
   endproperty
   a_sda_change: assert property (p_sda_change)
      else $error("data line changed with bus clock high");
   property p_ack_hold;
      $fell(sdaOeN) |=> (!sdaOeN) [*3];
   endproperty
   a_ack_hold: assert property (p_ack_hold)
      else $error("pulled-low data bit not held");
   // sequence restarts at the local channel
   property p_reset_start;
      $fell(reset) |-> convStart && convChan == 3'h0;
   endproperty
   a_reset_start: assert property (p_reset_start)
      else $error("sequence not restarted at local channel");
   property p_start_once;
      convStart |=> !convStart;
   endproperty
   a_start_once: assert property (p_start_once)
      else $error("conversion request longer than one cycle");
   property p_chan_hold;
      convStart |=> $stable(convChan) [*2];
   endproperty
   a_chan_hold: assert property (p_chan_hold)
      else $error("channel moved during conversion");
   // good result: adjust, store, then next request
   property p_settle;
      convDone && (!convFault || convChan == 3'h0) |->
         s_quiet ##[1:8] convStart;
   endproperty
   a_settle: assert property (p_settle)
      else $error("next request not after the adjust latency");
   // faulted remote channel: move on at once
   property p_fault_skip;
      convDone && convFault && convChan != 3'h0 |->
         !convStart ##[1:8] convStart;
   endproperty
   a_fault_skip: assert property (p_fault_skip)
      else $error("faulted channel not skipped promptly");
endmodule

bind rtoa_top rtoa_checker u_checker (
   .clk(clk), .reset(reset), .sclIn(sclIn), .sdaIn(sdaIn),
   .sdaOut(sdaOut), .sdaOeN(sdaOeN), .alertOut(alertOut),
   .alertOeN(alertOeN), .shutdownAlarmOut(shutdownAlarmOut),
   .shutdownAlarmOeN(shutdownAlarmOeN), .convStart(convStart),
   .convChan(convChan), .convDone(convDone), .convRaw(convRaw),
   .convFault(convFault)
);

// ---- tb/rtoa_smbus_host.sv ----
// serial bus host model that programs the offset stage
`timescale 1ns/100ps
module rtoa_smbus_host
   import rtoa_pkg::*;
(
   // clock
   input wire logic clk,
   // open-drain bus, released means high
   output logic scl,
   output logic sdaDrv,
   input wire logic sda
);
   // quarter bit in clk cycles; target wants four per phase at least
   localparam int QTR = 4;
   initial begin
      scl = 1'b1;
      sdaDrv = 1'b1;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   // start or repeated start, data falls while clock high
   task automatic startCond();
      sdaDrv <= 1'b1;
      tick(QTR);
      scl <= 1'b1;
      tick(2 * QTR);
      sdaDrv <= 1'b0;
      tick(2 * QTR);
      scl <= 1'b0;
      tick(QTR);
   endtask
   task automatic stopCond();
      sdaDrv <= 1'b0;
      tick(QTR);
      scl <= 1'b1;
      tick(2 * QTR);
      sdaDrv <= 1'b1;
      tick(2 * QTR);
   endtask
   // data set mid-low, sampled mid-high
   task automatic bitX(input logic b, output logic r);
      sdaDrv <= b;
      tick(QTR);
      scl <= 1'b1;
      tick(QTR);
      r = sda;
      tick(QTR);
      scl <= 1'b0;
      tick(QTR);
   endtask
   task automatic byteX(input logic [7:0] d, input logic ackIn,
         output logic [7:0] q, output logic ack);
      logic b;
      for (int i = 7; i >= 0; i--) begin
         bitX(d[i], b);
         q[i] = b;
      end
      bitX(ackIn, ack);
   endtask
   task automatic writeReg(input logic [6:0] dev, input logic [7:0] cmd,
         input logic [7:0] data, output logic ok);
      logic [7:0] q;
      logic a0, a1, a2;
      startCond();
      byteX({dev, 1'b0}, 1'b1, q, a0);
      byteX(cmd, 1'b1, q, a1);
      byteX(data, 1'b1, q, a2);
      stopCond();
      ok = !a0 && !a1 && !a2;
   endtask
   // last byte is refused so the target lets go of the bus
   task automatic readReg(input logic [6:0] dev, input logic [7:0] cmd,
         output logic [7:0] data, output logic ok);
      logic [7:0] q;
      logic a0, a1, a2, a3;
      startCond();
      byteX({dev, 1'b0}, 1'b1, q, a0);
      byteX(cmd, 1'b1, q, a1);
      startCond();
      byteX({dev, 1'b1}, 1'b1, q, a2);
      byteX(8'hff, 1'b1, data, a3);
      stopCond();
      ok = !a0 && !a1 && !a2;
   endtask
   // unused channels masked in both alarm masks after power-up
   task automatic maskUnused(input logic [7:0] m);
      logic ok;
      writeReg(TARGET_ADDR, REG_ALERT_MASK, m, ok);
      writeReg(TARGET_ADDR, REG_SHDN_MASK, m, ok);
   endtask
endmodule

// ---- tb/rtoa_tb.sv ----
// self-checking bench with converter stand-in and bus host
`timescale 1ns/100ps
module rtoa_tb
   import rtoa_pkg::*;
;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic hostScl, hostSda, sdaLevel, sdaOut, sdaOeN, alertOut, alertOeN;
   logic shutdownAlarmOut, shutdownAlarmOeN, convStart, convDone;
   logic convFault, rdValid = 1'b0;
   logic [2:0] convChan;
   logic [RAW_W-1:0] convRaw;
   logic [RAW_W-1:0] rawTab [8];
   logic faultTab [8];
   logic skipSeen [8];
   logic [7:0] expQ [$];
   logic [7:0] rdData;
   logic [31:0] seed = 32'h0000b7b3;
   int numErrors = 0;
   int comparisons = 0;
   int sweeps = 0;
   always #5 clk = ~clk;
   // open-drain wire: anyone pulling low wins
   assign sdaLevel = hostSda & (sdaOeN | sdaOut);
   rtoa_top dut (
      .clk(clk), .reset(reset), .sclIn(hostScl), .sdaIn(sdaLevel),
      .sdaOut(sdaOut), .sdaOeN(sdaOeN), .alertOut(alertOut),
      .alertOeN(alertOeN), .shutdownAlarmOut(shutdownAlarmOut),
      .shutdownAlarmOeN(shutdownAlarmOeN), .convStart(convStart),
      .convChan(convChan), .convDone(convDone), .convRaw(convRaw),
      .convFault(convFault)
   );
   rtoa_smbus_host host (.clk(clk), .scl(hostScl), .sdaDrv(hostSda),
      .sda(sdaLevel));
   ////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // floor of quarter degrees, range shift, then saturate
   function automatic logic [7:0] expTemp(input logic [11:0] raw,
         input logic [7:0] off, input logic en, input logic ext);
      int v;
      v = int'($signed(raw));
      if (en) v += int'($signed(off));
      v = (v >>> 2) + (ext ? 64 : 0);
      if (v < 0) v = 0;
      if (v > 255) v = 255;
      return v[7:0];
   endfunction
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         numErrors++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic finishTest();
      if (numErrors == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic waitSweeps(input int n);
      int target;
      target = sweeps + n;
      for (int i = 0; i < 20000 && sweeps < target; i++) @(posedge clk);
      if (sweeps < target) begin
         numErrors++;
         finishTest();
      end
   endtask
   task automatic wr(input logic [7:0] cmd, input logic [7:0] data);
      logic ok;
      host.writeReg(TARGET_ADDR, cmd, data, ok);
      check({7'h00, ok}, 8'h01);
   endtask
   // note the expectation, then let the monitor compare
   task automatic rd(input logic [7:0] cmd, input logic [7:0] exp);
      logic [7:0] d;
      logic ok;
      expQ.push_back(exp);
      host.readReg(TARGET_ADDR, cmd, d, ok);
      check({7'h00, ok}, 8'h01);
      rdData <= d;
      rdValid <= 1'b1;
      @(posedge clk);
      rdValid <= 1'b0;
   endtask
   // compare each read against the oldest note
   always @(posedge clk) begin
      if (rdValid === 1'b1) begin
         if (expQ.size() == 0) check(8'h00, 8'h01);
         else check(rdData, expQ.pop_front());
      end
   end
   // converter: random latency, faulted diode answers with a fault
   initial begin
      int ch;
      convDone = 1'b0;
      convRaw = 12'h000;
      convFault = 1'b0;
      forever begin
         @(negedge clk);
         if (!reset && convStart) begin
            ch = convChan;
            if (skipSeen[ch]) check(8'h01, 8'h00);
            repeat (3 + rnd() % 4) @(posedge clk);
            convDone <= 1'b1;
            convRaw <= rawTab[ch];
            convFault <= faultTab[ch];
            if (faultTab[ch] && ch != 0) skipSeen[ch] = 1'b1;
            if (ch == 7) sweeps++;
            @(posedge clk);
            convDone <= 1'b0;
            convRaw <= ~rawTab[ch];
            convFault <= 1'b0;
         end
      end
   end
   // main sequence; channel 3 has no diode fitted
   initial begin
      logic [31:0] r;
      logic [7:0] off, en;
      logic ext, ok, e;
      for (int c = 0; c < 8; c++) begin
         rawTab[c] = 12'h0c8;
         faultTab[c] = (c == 3);
         skipSeen[c] = 1'b0;
      end
      repeat (10) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      host.maskUnused(8'h08);
      rd(REG_SHARED_OFFSET, 8'h00);
      rd(REG_OFFSET_ENABLE, 8'h00);
      rd(8'h30, 8'h00);
      host.writeReg(7'h4c, REG_SHARED_OFFSET, 8'h55, ok);
      check({7'h00, ok}, 8'h00);
      rd(REG_SHARED_OFFSET, 8'h00);
      rd(REG_DIODE_FAULT, 8'h04);
      for (int k = 0; k < 6; k++) begin
         r = rnd();
         off = r[7:0];
         en = r[15:8];
         ext = r[16];
         if (k == 4) {off, ext} = {8'h80, 1'b0};
         if (k == 5) {off, ext} = {8'h7f, 1'b1};
         for (int c = 0; c < 8; c++) begin
            r = rnd();
            rawTab[c] = (k == 4) ? {8'h00, r[3:0]} : r[RAW_W-1:0];
            if (k == 5) rawTab[c] = 12'h300;
         end
         wr(REG_SHARED_OFFSET, off);
         wr(REG_OFFSET_ENABLE, en);
         wr(REG_CONFIG, {7'h00, ext});
         rd(REG_SHARED_OFFSET, off);
         rd(REG_OFFSET_ENABLE, en & 8'h7f);
         waitSweeps(2);
         for (int c = 0; c < 8; c++) begin
            e = (c == 0) ? 1'b0 : en[c - 1];
            r = {24'h0, expTemp(rawTab[c], off, e, ext)};
            if (c != 3) rd(REG_TEMP_BASE + c[7:0], r[7:0]);
         end
      end
      wr(REG_ALERT_LIMIT, 8'h00);
      wr(REG_SHDN_LIMIT, 8'h00);
      host.maskUnused(8'hff);
      waitSweeps(2);
      check({6'h00, alertOeN, shutdownAlarmOeN}, 8'h03);
      wr(REG_ALERT_MASK, 8'h08);
      waitSweeps(1);
      check({6'h00, alertOeN, shutdownAlarmOeN}, 8'h01);
      finishTest();
   end
endmodule
